/* rtl/tcc_pkg.sv */
// Shared constants for the timer capture/compare unit.
package tcc_pkg;

    // ====================
    // Register map, byte addresses on the register bus
    localparam int         ADDR_W         = 5;
    localparam logic [4:0] ADDR_CONTROL   = 5'h00;
    localparam logic [4:0] ADDR_LOW_BYTE  = 5'h04;
    localparam logic [4:0] ADDR_HIGH_BYTE = 5'h08;
    localparam logic [4:0] ADDR_STATUS    = 5'h0C;
    localparam logic [4:0] ADDR_MASK      = 5'h10;
    localparam logic [4:0] ADDR_PORT      = 5'h14;

    // ====================
    // Fields and reset values
    localparam int         TIMER_W        = 16;
    localparam logic [7:0] CONTROL_RESET  = 8'h00;
    localparam logic [7:0] CONTROL_WMASK  = 8'hBF;
    localparam int         MODE_LSB       = 0;
    localparam int         FLAG_BIT       = 0;
    localparam int         ENABLE_BIT     = 0;
    localparam int         PORT_DIR_BIT   = 0;
    localparam int         PORT_DATA_BIT  = 1;
    localparam logic       DIR_RESET      = 1'h1;
    localparam logic       DATA_RESET     = 1'h0;

    // ====================
    // Mode select field codes
    localparam logic [3:0] MODE_OFF       = 4'h0;
    localparam logic [3:0] MODE_CMP_TOG   = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL  = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE  = 4'h5;
    localparam logic [3:0] MODE_CAP_4TH   = 4'h6;
    localparam logic [3:0] MODE_CAP_16TH  = 4'h7;
    localparam logic [3:0] MODE_CMP_SET   = 4'h8;
    localparam logic [3:0] MODE_CMP_CLR   = 4'h9;
    localparam logic [3:0] MODE_CMP_SWI   = 4'hA;
    localparam logic [3:0] MODE_CMP_SPEC  = 4'hB;

    // ====================
    // Prescaler terminal counts
    localparam logic [1:0] PRESC_LAST_4   = 2'h3;
    localparam logic [3:0] PRESC_LAST_16  = 4'hF;

    // ====================
    // Bus responses
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

endpackage

/* rtl/tcc_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps

module tcc_pin_sync (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic pin_in,
    output logic      level_out
);

    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic level_r;
    logic level_nxt;

    // A level change is accepted only once stages two and three agree.
    always_comb begin
        level_nxt = (sync2_r == sync3_r) ? sync3_r : level_r;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
            level_r <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            level_r <= level_nxt;
        end
    end

    assign level_out = level_r;

endmodule

/* rtl/tcc_unit.sv */
// Timer capture/compare unit with AXI4-Lite register slave.
// Function
// RQ1: Capture copies timer count into holding pair.
// RQ2: Mode picks falling, rising, 4th, 16th edge.
// RQ3: Capture sets interrupt flag; software clears it.
// RQ4: Newer capture overwrites unread holding value.
// RQ5: Software should set pin as input.
// RQ6: Port write on output pin can capture.
// RQ7: Timer must run synchronously to this clock.
// RQ8: Mode change may raise flag; software clears.
// RQ9: Prescaler cleared when off, non-capture, reset.
// RQ10: Prescaler switch keeps count; software writes zero.
// RQ11: Compare each cycle; match toggles, sets, clears.
// RQ12: Every compare match sets interrupt flag.
// RQ13: Holding pair keeps contents across resets.
// RQ14: Software interrupt mode leaves pin alone.
// RQ15: Special trigger resets timer, starts conversion.
// RQ16: Timer reset at next tick if match holds.
// RQ17: Control write of zero clears compare latch.
// RQ18: Pin synchronised; one event per edge.
// RQ19: Control zero means off: pin released, idle.
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module tcc_unit (
    input  wire logic                       clk_in,
    input  wire logic                       rst_in,
    input  wire logic [tcc_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic                       s_axi_awvalid_in,
    output logic                            s_axi_awready_out,
    input  wire logic [31:0]                s_axi_wdata_in,
    input  wire logic [3:0]                 s_axi_wstrb_in,
    input  wire logic                       s_axi_wvalid_in,
    output logic                            s_axi_wready_out,
    output logic [1:0]                      s_axi_bresp_out,
    output logic                            s_axi_bvalid_out,
    input  wire logic                       s_axi_bready_in,
    input  wire logic [tcc_pkg::ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic                       s_axi_arvalid_in,
    output logic                            s_axi_arready_out,
    output logic [31:0]                     s_axi_rdata_out,
    output logic [1:0]                      s_axi_rresp_out,
    output logic                            s_axi_rvalid_out,
    input  wire logic                       s_axi_rready_in,
    input  wire logic                       pin_in,
    output logic                            pin_out,
    output logic                            pin_oe_n_out,
    input  wire logic [tcc_pkg::TIMER_W-1:0] timer_count_in,
    input  wire logic                       timer_tick_in,
    output logic                            timer_reset_out,
    output logic                            special_event_out,
    input  wire logic                       adc_enable_in,
    output logic                            adc_start_out,
    output logic                            irq_out
);

    // ====================
    // State
    logic [tcc_pkg::ADDR_W-1:0]  aw_addr_r, aw_addr_nxt;
    logic [7:0]                  w_byte_r, w_byte_nxt;
    logic                        w_lane_r, w_lane_nxt;
    logic                        aw_held_r, aw_held_nxt;
    logic                        w_held_r, w_held_nxt;
    logic                        bvalid_r, bvalid_nxt;
    logic [1:0]                  bresp_r, bresp_nxt;
    logic                        rvalid_r, rvalid_nxt;
    logic [1:0]                  rresp_r, rresp_nxt;
    logic [31:0]                 rdata_r, rdata_nxt;
    logic [7:0]                  ctrl_r, ctrl_nxt;
    logic [tcc_pkg::TIMER_W-1:0] hold_r, hold_nxt;
    logic                        flag_r, flag_nxt;
    logic                        enable_r, enable_nxt;
    logic                        dir_r, dir_nxt;
    logic                        port_r, port_nxt;
    logic [3:0]                  presc_r, presc_nxt;
    logic                        eff_prev_r, eff_prev_nxt;
    logic                        match_prev_r, match_prev_nxt;
    logic                        cmp_latch_r, cmp_latch_nxt;

    logic [3:0] mode;
    logic       is_capture;
    logic       unit_drives;
    logic       pin_level;
    logic       eff_level;
    logic       pin_rise;
    logic       pin_fall;
    logic       cap_event;
    logic       match;
    logic       match_evt;
    logic       wr_fire;
    logic       wr_en;
    logic       wr_ok;
    logic       flag_clear;

    tcc_pin_sync u_sync (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .pin_in    (pin_in),
        .level_out (pin_level)
    );

    // ====================
    // Mode decode and pin path
    assign mode        = ctrl_r[tcc_pkg::MODE_LSB +: 4];
    assign is_capture  = (mode == tcc_pkg::MODE_CAP_FALL) || (mode == tcc_pkg::MODE_CAP_RISE)
                      || (mode == tcc_pkg::MODE_CAP_4TH)  || (mode == tcc_pkg::MODE_CAP_16TH);
    // Only toggle, set and clear modes own the pin; trigger modes never do.
    assign unit_drives = (mode == tcc_pkg::MODE_CMP_TOG) || (mode == tcc_pkg::MODE_CMP_SET)
                      || (mode == tcc_pkg::MODE_CMP_CLR); // RQ14 RQ15 RQ19
    assign pin_out      = unit_drives ? cmp_latch_r : port_r;
    assign pin_oe_n_out = dir_r;
    // An output pin is watched at its driven value, so a port write can capture.
    assign eff_level = dir_r ? pin_level : pin_out; // RQ6 RQ18
    assign pin_rise  = eff_level && !eff_prev_r; // RQ18
    assign pin_fall  = !eff_level && eff_prev_r; // RQ18
    // The timer count is used unsynchronised: it must share this clock.
    assign match     = !is_capture && (mode != tcc_pkg::MODE_OFF) && (mode[3:2] != 2'h3)
                    && (mode != 4'h1) && (mode != 4'h3)
                    && (hold_r == timer_count_in); // RQ7 RQ11
    assign match_evt = match && !match_prev_r; // RQ11

    assign special_event_out = match && (mode == tcc_pkg::MODE_CMP_SPEC); // RQ15 RQ16
    assign timer_reset_out   = special_event_out && timer_tick_in; // RQ16
    assign adc_start_out     = match_evt && (mode == tcc_pkg::MODE_CMP_SPEC)
                            && adc_enable_in; // RQ15
    assign irq_out           = flag_r && enable_r;

    // ====================
    // Bus handshake
    assign s_axi_awready_out = !aw_held_r && !bvalid_r;
    assign s_axi_wready_out  = !w_held_r && !bvalid_r;
    assign s_axi_bvalid_out  = bvalid_r;
    assign s_axi_bresp_out   = bresp_r;
    assign s_axi_arready_out = !rvalid_r;
    assign s_axi_rvalid_out  = rvalid_r;
    assign s_axi_rresp_out   = rresp_r;
    assign s_axi_rdata_out   = rdata_r;

    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
    assign wr_ok   = (aw_addr_r == tcc_pkg::ADDR_CONTROL) || (aw_addr_r == tcc_pkg::ADDR_LOW_BYTE)
                  || (aw_addr_r == tcc_pkg::ADDR_HIGH_BYTE) || (aw_addr_r == tcc_pkg::ADDR_STATUS)
                  || (aw_addr_r == tcc_pkg::ADDR_MASK) || (aw_addr_r == tcc_pkg::ADDR_PORT);
    assign wr_en   = wr_fire && w_lane_r && wr_ok;
    assign flag_clear = wr_en && (aw_addr_r == tcc_pkg::ADDR_STATUS)
                     && w_byte_r[tcc_pkg::FLAG_BIT];

    always_comb begin
        aw_addr_nxt = aw_addr_r;
        aw_held_nxt = aw_held_r;
        w_byte_nxt  = w_byte_r;
        w_lane_nxt  = w_lane_r;
        w_held_nxt  = w_held_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_addr_nxt = s_axi_awaddr_in;
            aw_held_nxt = 1'b1;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_byte_nxt = s_axi_wdata_in[7:0];
            w_lane_nxt = s_axi_wstrb_in[0];
            w_held_nxt = 1'b1;
        end
        if (wr_fire) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = wr_ok ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready_in) begin
            bvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = tcc_pkg::RESP_OKAY;
            rdata_nxt  = 32'h0000_0000;
            unique case (s_axi_araddr_in)
                tcc_pkg::ADDR_CONTROL:   rdata_nxt[7:0] = ctrl_r;
                tcc_pkg::ADDR_LOW_BYTE:  rdata_nxt[7:0] = hold_r[7:0];
                tcc_pkg::ADDR_HIGH_BYTE: rdata_nxt[7:0] = hold_r[15:8];
                tcc_pkg::ADDR_STATUS:    rdata_nxt[tcc_pkg::FLAG_BIT] = flag_r;
                tcc_pkg::ADDR_MASK:      rdata_nxt[tcc_pkg::ENABLE_BIT] = enable_r;
                tcc_pkg::ADDR_PORT: begin
                    rdata_nxt[tcc_pkg::PORT_DIR_BIT]  = dir_r;
                    rdata_nxt[tcc_pkg::PORT_DATA_BIT] = port_r;
                end
                default:                 rresp_nxt = tcc_pkg::RESP_SLVERR;
            endcase
        end else if (rvalid_r && s_axi_rready_in) begin
            rvalid_nxt = 1'b0;
        end
    end

    // ====================
    // Capture, compare and register updates
    always_comb begin
        cap_event      = 1'b0;
        presc_nxt      = presc_r;
        eff_prev_nxt   = eff_level;
        match_prev_nxt = match;
        ctrl_nxt       = ctrl_r;
        enable_nxt     = enable_r;
        dir_nxt        = dir_r;
        port_nxt       = port_r;
        hold_nxt       = hold_r;
        cmp_latch_nxt  = cmp_latch_r;
        // Switching between prescaled modes keeps the count on purpose.
        if (!is_capture) begin
            presc_nxt = 4'h0; // RQ9 RQ10 RQ19
        end else begin
            unique case (mode)
                tcc_pkg::MODE_CAP_FALL: cap_event = pin_fall; // RQ2
                tcc_pkg::MODE_CAP_RISE: cap_event = pin_rise; // RQ2
                tcc_pkg::MODE_CAP_4TH: begin
                    cap_event = pin_rise && (presc_r[1:0] == tcc_pkg::PRESC_LAST_4); // RQ2
                end
                default: begin
                    cap_event = pin_rise && (presc_r == tcc_pkg::PRESC_LAST_16); // RQ2
                end
            endcase
            if (pin_rise) begin
                presc_nxt = presc_r + 4'h1;
            end
        end
        if (wr_en) begin
            unique case (aw_addr_r)
                tcc_pkg::ADDR_CONTROL: begin
                    ctrl_nxt = w_byte_r & tcc_pkg::CONTROL_WMASK;
                    if (w_byte_r == 8'h00) begin
                        cmp_latch_nxt = 1'b0; // RQ17
                    end
                end
                tcc_pkg::ADDR_LOW_BYTE:  hold_nxt[7:0]  = w_byte_r;
                tcc_pkg::ADDR_HIGH_BYTE: hold_nxt[15:8] = w_byte_r;
                tcc_pkg::ADDR_MASK:      enable_nxt = w_byte_r[tcc_pkg::ENABLE_BIT];
                tcc_pkg::ADDR_PORT: begin
                    dir_nxt  = w_byte_r[tcc_pkg::PORT_DIR_BIT];
                    port_nxt = w_byte_r[tcc_pkg::PORT_DATA_BIT];
                end
                default: begin
                end
            endcase
        end
        // A capture beats a same-cycle software write to the pair.
        if (cap_event) begin
            hold_nxt = timer_count_in; // RQ1 RQ4
        end
        if (match_evt && !(wr_en && (aw_addr_r == tcc_pkg::ADDR_CONTROL))) begin
            unique case (mode)
                tcc_pkg::MODE_CMP_TOG: cmp_latch_nxt = !cmp_latch_r; // RQ11
                tcc_pkg::MODE_CMP_SET: cmp_latch_nxt = 1'b1; // RQ11
                tcc_pkg::MODE_CMP_CLR: cmp_latch_nxt = 1'b0; // RQ11
                default: begin
                end
            endcase
        end
        // Hardware set wins over a same-cycle software clear.
        flag_nxt = (flag_r && !flag_clear) || cap_event || match_evt; // RQ3 RQ8 RQ12
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            aw_addr_r    <= '0;
            aw_held_r    <= 1'b0;
            w_byte_r     <= 8'h00;
            w_lane_r     <= 1'b0;
            w_held_r     <= 1'b0;
            bvalid_r     <= 1'b0;
            bresp_r      <= tcc_pkg::RESP_OKAY;
            rvalid_r     <= 1'b0;
            rresp_r      <= tcc_pkg::RESP_OKAY;
            rdata_r      <= 32'h0000_0000;
            ctrl_r       <= tcc_pkg::CONTROL_RESET;
            flag_r       <= 1'b0;
            enable_r     <= 1'b0;
            dir_r        <= tcc_pkg::DIR_RESET;
            port_r       <= tcc_pkg::DATA_RESET;
            presc_r      <= 4'h0; // RQ9
            eff_prev_r   <= 1'b0;
            match_prev_r <= 1'b0;
            cmp_latch_r  <= 1'b0;
        end else begin
            aw_addr_r    <= aw_addr_nxt;
            aw_held_r    <= aw_held_nxt;
            w_byte_r     <= w_byte_nxt;
            w_lane_r     <= w_lane_nxt;
            w_held_r     <= w_held_nxt;
            bvalid_r     <= bvalid_nxt;
            bresp_r      <= bresp_nxt;
            rvalid_r     <= rvalid_nxt;
            rresp_r      <= rresp_nxt;
            rdata_r      <= rdata_nxt;
            ctrl_r       <= ctrl_nxt;
            flag_r       <= flag_nxt;
            enable_r     <= enable_nxt;
            dir_r        <= dir_nxt;
            port_r       <= port_nxt;
            presc_r      <= presc_nxt;
            eff_prev_r   <= eff_prev_nxt;
            match_prev_r <= match_prev_nxt;
            cmp_latch_r  <= cmp_latch_nxt;
        end
    end

    // The holding pair has no reset so it survives every reset.
    always_ff @(posedge clk_in) begin
        hold_r <= hold_nxt; // RQ13
    end

    // ====================
    // Assertions
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence cap_seen;
        cap_event;
    endsequence
    sequence rise_seen;
        pin_rise;
    endsequence

    capture_copy_a: assert property (cap_seen |=> hold_r == $past(timer_count_in)) // RQ1
        else $error("capture did not copy timer count");
    fourth_edge_a: assert property (cap_event && mode == tcc_pkg::MODE_CAP_4TH
                                    |-> pin_rise && presc_r[1:0] == 2'h3) // RQ2
        else $error("4th edge capture at wrong count");
    flag_set_a: assert property ((cap_event || match_evt) |=> flag_r) // RQ3
        else $error("event did not set flag");
    flag_sticky_a: assert property (flag_r && !flag_clear |=> flag_r) // RQ3
        else $error("flag cleared without software");
    presc_clear_a: assert property (!is_capture |=> presc_r == 4'h0) // RQ9
        else $error("prescaler not cleared");
    toggle_match_a: assert property (match_evt && mode == tcc_pkg::MODE_CMP_TOG && !wr_en
                                     |=> cmp_latch_r != $past(cmp_latch_r)) // RQ11
        else $error("toggle on match missing");
    match_flag_a: assert property (match && !match_prev_r |=> flag_r) // RQ12
        else $error("compare match did not set flag");
    swi_pin_a: assert property (mode == tcc_pkg::MODE_CMP_SWI |-> pin_out == port_r) // RQ14
        else $error("software interrupt mode drove pin");
    special_reset_a: assert property (timer_reset_out |-> hold_r == timer_count_in
                                      && mode == tcc_pkg::MODE_CMP_SPEC) // RQ15 RQ16
        else $error("timer reset without match");
    latch_zero_a: assert property (wr_en && aw_addr_r == tcc_pkg::ADDR_CONTROL
                                   && w_byte_r == 8'h00 |=> !cmp_latch_r ##1 !cmp_latch_r) // RQ17
        else $error("compare latch not cleared");
    single_edge_a: assert property (rise_seen |=> !pin_rise) // RQ18
        else $error("edge produced two events");
    off_idle_a: assert property (ctrl_r == 8'h00 |-> !cap_event && !match
                                 && pin_out == port_r) // RQ19
        else $error("off unit still active");

endmodule

/* sim/tcc_partner.sv */
// Far-side model: the sixteen-bit timer and the unit pin wire.
`timescale 1ns/1ps

module tcc_partner (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        run_in,
    input  wire logic        load_in,
    input  wire logic [15:0] load_val_in,
    input  wire logic        timer_reset_in,
    input  wire logic        ext_level_in,
    input  wire logic        unit_pin_in,
    input  wire logic        unit_oe_n_in,
    output logic [15:0]      count_out,
    output logic             tick_out,
    output logic             pin_wire_out
);
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic        tick_r;
    logic        tick_nxt;

    // Ticks every second clock, so a match spans two cycles as with a slow timer clock.
    always_comb begin
        tick_nxt  = run_in & ~tick_r;
        count_nxt = count_r;
        if (load_in)
            count_nxt = load_val_in;
        else if (tick_r && timer_reset_in)
            count_nxt = 16'h0000;
        else if (tick_r)
            count_nxt = count_r + 16'h0001;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_r <= 16'h0000;
            tick_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tick_r  <= tick_nxt;
        end
    end

    assign count_out    = count_r;
    assign tick_out     = tick_r;
    assign pin_wire_out = unit_oe_n_in ? ext_level_in : unit_pin_in;
endmodule

/* sim/timer_capture_compare_unit_tb.sv */
// Self-checking bench for the timer capture/compare unit.
`timescale 1ns/1ps

module timer_capture_compare_unit_tb;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
    logic        awready, wready, bvalid, arready, rvalid, pin_out, oe_n;
    logic [1:0]  bresp, rresp;
    logic        tmr_rst, spec, adc_start, irq, tick, pin_wire;
    logic        run = 0, load = 0, ext = 0;
    logic [15:0] load_val = 16'h0000, count;
    int          error_cnt = 0, tests_run = 0, cyc = 0, adc_cnt = 0;
    logic [3:0]  modes [5] = '{tcc_pkg::MODE_CMP_SET, tcc_pkg::MODE_CMP_CLR,
        tcc_pkg::MODE_CMP_SWI, tcc_pkg::MODE_CMP_SPEC, tcc_pkg::MODE_CMP_TOG};
    logic        pins [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};

    tcc_unit uut (.clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .pin_in(pin_wire), .pin_out(pin_out), .pin_oe_n_out(oe_n),
        .timer_count_in(count), .timer_tick_in(tick), .timer_reset_out(tmr_rst),
        .special_event_out(spec), .adc_enable_in(1'b1), .adc_start_out(adc_start),
        .irq_out(irq));

    tcc_partner far (.clk_in(clk_in), .rst_in(rst_in), .run_in(run), .load_in(load),
        .load_val_in(load_val), .timer_reset_in(tmr_rst), .ext_level_in(ext),
        .unit_pin_in(pin_out), .unit_oe_n_in(oe_n), .count_out(count), .tick_out(tick),
        .pin_wire_out(pin_wire));

    // ====================
    // Clock, timeout and closing report
    initial begin
        forever #20 clk_in = ~clk_in;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // The run needs about 1000 cycles.
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (adc_start === 1'b1)
            adc_cnt++;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    // ====================
    // Comparison and bus tasks
    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        if (g !== e)
            error_cnt++;
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_val(nm, 32'(e), 32'(g));
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
        bit aw_ok = 0, w_ok = 0;
        awaddr <= a;
        wdata <= 32'(d);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_in);
            aw_ok |= awready === 1'b1;
            w_ok |= wready === 1'b1;
            if (aw_ok)
                awvalid <= 1'b0;
            if (w_ok)
                wvalid <= 1'b0;
        end
        do @(posedge clk_in); while (bvalid !== 1'b1);
        chk_val("write response", 32'(er), 32'(bresp));
    endtask

    task automatic rchk(input logic [4:0] a, input logic [7:0] e, input logic [1:0] er);
        bit ar_ok = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk_in);
            ar_ok |= arready === 1'b1;
            if (ar_ok)
                arvalid <= 1'b0;
        end while (!(ar_ok && rvalid === 1'b1));
        chk_val("read response", 32'(er), 32'(rresp));
        chk_val("read data", 32'(e), rdata);
    endtask

    task automatic tload(input logic [15:0] v);
        load_val <= v;
        load <= 1'b1;
        idle(1);
        load <= 1'b0;
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            ext <= 1'b1;
            idle(8);
            ext <= 1'b0;
            idle(8);
        end
    endtask

    // A mode change is made with the interrupt masked and followed by a flag clear.
    task automatic set_mode(input logic [3:0] m);
        wr(tcc_pkg::ADDR_MASK, 8'h00, tcc_pkg::RESP_OKAY);
        wr(tcc_pkg::ADDR_CONTROL, 8'h00, tcc_pkg::RESP_OKAY);
        wr(tcc_pkg::ADDR_CONTROL, {4'h0, m}, tcc_pkg::RESP_OKAY);
        wr(tcc_pkg::ADDR_STATUS, 8'h01, tcc_pkg::RESP_OKAY);
        wr(tcc_pkg::ADDR_MASK, 8'h01, tcc_pkg::RESP_OKAY);
    endtask

    // ====================
    // Test sequence
    initial begin
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        idle(1);
        rchk(tcc_pkg::ADDR_CONTROL, 8'h00, tcc_pkg::RESP_OKAY);
        rchk(tcc_pkg::ADDR_PORT, 8'h01, tcc_pkg::RESP_OKAY);
        rchk(tcc_pkg::ADDR_STATUS, 8'h00, tcc_pkg::RESP_OKAY);
        rchk(5'h18, 8'h00, tcc_pkg::RESP_SLVERR);
        wr(5'h1C, 8'hFF, tcc_pkg::RESP_SLVERR);
        chk_bit("oe_n", 1'b1, oe_n);
        $display("test reset done");
        tload(16'h1234);
        set_mode(tcc_pkg::MODE_CAP_RISE);
        pulses(1);
        chk_bit("irq", 1'b1, irq);
        rchk(tcc_pkg::ADDR_LOW_BYTE, 8'h34, tcc_pkg::RESP_OKAY);
        rchk(tcc_pkg::ADDR_HIGH_BYTE, 8'h12, tcc_pkg::RESP_OKAY);
        idle(20);
        rchk(tcc_pkg::ADDR_STATUS, 8'h01, tcc_pkg::RESP_OKAY);
        wr(tcc_pkg::ADDR_STATUS, 8'h01, tcc_pkg::RESP_OKAY);
        rchk(tcc_pkg::ADDR_STATUS, 8'h00, tcc_pkg::RESP_OKAY);
        chk_bit("irq", 1'b0, irq);
        $display("test rising capture done");
        set_mode(tcc_pkg::MODE_CAP_FALL);
        tload(16'hBEEF);
        pulses(1);
        tload(16'hCAFE);
        pulses(1);
        rchk(tcc_pkg::ADDR_LOW_BYTE, 8'hFE, tcc_pkg::RESP_OKAY);
        rchk(tcc_pkg::ADDR_HIGH_BYTE, 8'hCA, tcc_pkg::RESP_OKAY);
        set_mode(tcc_pkg::MODE_CAP_4TH);
        pulses(3);
        rchk(tcc_pkg::ADDR_STATUS, 8'h00, tcc_pkg::RESP_OKAY);
        pulses(1);
        rchk(tcc_pkg::ADDR_STATUS, 8'h01, tcc_pkg::RESP_OKAY);
        set_mode(tcc_pkg::MODE_CAP_16TH);
        pulses(15);
        rchk(tcc_pkg::ADDR_STATUS, 8'h00, tcc_pkg::RESP_OKAY);
        pulses(1);
        rchk(tcc_pkg::ADDR_STATUS, 8'h01, tcc_pkg::RESP_OKAY);
        $display("test prescaler done");
        rst_in <= 1'b1;
        idle(2);
        rst_in <= 1'b0;
        idle(1);
        rchk(tcc_pkg::ADDR_HIGH_BYTE, 8'hCA, tcc_pkg::RESP_OKAY);
        wr(tcc_pkg::ADDR_PORT, 8'h00, tcc_pkg::RESP_OKAY);
        set_mode(tcc_pkg::MODE_CAP_RISE);
        tload(16'h0F0F);
        wr(tcc_pkg::ADDR_PORT, 8'h02, tcc_pkg::RESP_OKAY);
        idle(2);
        rchk(tcc_pkg::ADDR_STATUS, 8'h01, tcc_pkg::RESP_OKAY);
        rchk(tcc_pkg::ADDR_LOW_BYTE, 8'h0F, tcc_pkg::RESP_OKAY);
        chk_bit("oe_n", 1'b0, oe_n);
        $display("test port capture done");
        wr(tcc_pkg::ADDR_PORT, 8'h00, tcc_pkg::RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            tload(16'h0000);
            set_mode(modes[i]);
            wr(tcc_pkg::ADDR_LOW_BYTE, 8'h10, tcc_pkg::RESP_OKAY);
            wr(tcc_pkg::ADDR_HIGH_BYTE, 8'h00, tcc_pkg::RESP_OKAY);
            run <= 1'b1;
            idle(60);
            run <= 1'b0;
            idle(2);
            rchk(tcc_pkg::ADDR_STATUS, 8'h01, tcc_pkg::RESP_OKAY);
            chk_bit("pin", pins[i], pin_out);
            chk_bit("timer reset", i == 3, count <= 16'h0010);
        end
        chk_val("adc start", 1, adc_cnt);
        tload(16'h8000);
        wr(tcc_pkg::ADDR_CONTROL, 8'h00, tcc_pkg::RESP_OKAY);
        wr(tcc_pkg::ADDR_CONTROL, {4'h0, tcc_pkg::MODE_CMP_TOG}, tcc_pkg::RESP_OKAY);
        idle(2);
        chk_bit("pin", 1'b0, pin_out);
        $display("test compare done");
        complete_run();
    end
endmodule
